// ==== core/sac_regs.svh ====
`ifndef SAC_REGS_SVH
`define SAC_REGS_SVH

// apb register byte offsets
`define SAC_STATUS_OFS 12'h000
`define SAC_CTRL_OFS 12'h004
// control register: restart bit position
`define SAC_CTRL_RESTART_BIT 0
// attenuation word: bit that must end up low, maximum code (15.5 dB * 4)
`define SAC_WORD_BIT7 7
`define SAC_MAX_WORD 8'h3e
`define SAC_MIN_WORD 8'h00
// power-up timing
`define SAC_PUP_DELAY_NS 40000
`define SAC_CLK_NS 40
// pins need four edges after release to pass the sync into the sampled group, read on the fifth
`define SAC_SETTLE_CYC 10'h005

`endif

// ==== core/sac_pkg.sv ====
package sac_pkg;

    typedef enum logic [1:0] {
        SAC_PUP,
        SAC_DWAIT,
        SAC_RUN
    } sac_state_t;

    // pins from the host, sampled as one group
    typedef struct packed {
        logic sel;
        logic strobe;
        logic sclk;
        logic sdata;
        logic [4:0] pstep;
    } sac_pins_t;

    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [11:0] paddr;
        logic [31:0] pwdata;
    } sac_apb_req_t;

    typedef struct packed {
        sac_state_t st;
        logic [9:0] cnt;
        logic [7:0] core;
        logic [7:0] shift;
        sac_pins_t s1;
        sac_pins_t s2;
        sac_pins_t s3;
        sac_pins_t pins;
        logic seq_done;
        logic restart;
        logic [31:0] prdata;
    } sac_regs_t;

endpackage

// ==== core/sac_ctrl.sv ====
// Local design decisions: the APB register port and the register offsets.
`timescale 1ns/1ps
`include "sac_regs.svh"

module sac_ctrl #(
    parameter int PUP_DELAY_NS = `SAC_PUP_DELAY_NS,
    parameter int CLK_NS = `SAC_CLK_NS
) (
    // clock and reset
    input wire logic sys_clk_in,
    input wire logic reset_in,
    // host control pins
    input wire sac_pkg::sac_pins_t host_pins_in,
    // apb slave
    input wire sac_pkg::sac_apb_req_t apb_req_in,
    output logic [31:0] prdata_out,
    output logic pready_out,
    output logic pslverr_out,
    // attenuator core word
    output logic [7:0] step_attenuator_word_out
);
    import sac_pkg::*;

    // least wait, so round up
    localparam logic [9:0] PUP_CYC = 10'((PUP_DELAY_NS + CLK_NS - 1) / CLK_NS);

    sac_regs_t r;
    sac_regs_t nxt;
    logic sclk_rise;
    logic sdata_new;
    logic seq_set;
    logic acc;
    logic mapped;

    // parallel bits sit on word bits 5:1, 0.5 dB per lsb
    function automatic logic [7:0] par_word(input logic [4:0] p);
        par_word = {2'h0, p, 1'h0};
    endfunction

    function automatic logic addr_hit(input logic [11:0] a);
        addr_hit = (a == `SAC_STATUS_OFS) || (a == `SAC_CTRL_OFS);
    endfunction

    assign acc = apb_req_in.psel && apb_req_in.penable;
    assign mapped = addr_hit(apb_req_in.paddr);

    always_comb begin
        nxt = r;
        sclk_rise = 1'b0;
        seq_set = 1'b0;
        sdata_new = r.pins.sdata;
        nxt.s1 = host_pins_in;
        nxt.s2 = r.s1;
        nxt.s3 = r.s2;
        // a pin change counts once two stages agree
        if (r.s2 == r.s3) begin
            nxt.pins = r.s3;
            sclk_rise = r.s3.sclk && !r.pins.sclk;
            sdata_new = r.s3.sdata;
        end
        // shift runs in any mode, as the host clocks it
        if (sclk_rise) begin
            nxt.shift = {sdata_new, r.shift[7:1]};
        end
        nxt.restart = 1'b0;
        unique case (r.st)
            SAC_PUP: begin
                nxt.core = `SAC_MAX_WORD;
                nxt.cnt = r.cnt + 10'h001;
                // wait until the synchroniser holds real pin levels
                if (r.cnt == `SAC_SETTLE_CYC - 10'h001) begin
                    nxt.cnt = 10'h000;
                    if (!r.pins.sel && r.pins.strobe) begin
                        nxt.st = SAC_DWAIT;
                    end else begin
                        nxt.st = SAC_RUN;
                    end
                end
            end
            SAC_DWAIT: begin
                nxt.core = `SAC_MAX_WORD;
                nxt.cnt = r.cnt + 10'h001;
                if (r.cnt == PUP_CYC - 10'h001) begin
                    nxt.cnt = 10'h000;
                    nxt.st = SAC_RUN;
                    // pulled-down inputs read zero: minimum attenuation
                    nxt.core = par_word(r.pins.pstep);
                end
            end
            SAC_RUN: begin
                // mode follows the select pin live, no power cycle
                if (r.pins.strobe) begin
                    if (r.pins.sel) begin
                        nxt.core = r.shift;
                        if (!r.shift[`SAC_WORD_BIT7]) begin
                            nxt.seq_done = 1'b1;
                            seq_set = 1'b1;
                        end
                    end else begin
                        nxt.core = par_word(r.pins.pstep);
                    end
                end
            end
        endcase
        // apb: read data registered in the setup phase
        if (apb_req_in.psel && !apb_req_in.penable) begin
            nxt.prdata = 32'h0;
            if (apb_req_in.paddr == `SAC_STATUS_OFS) begin
                nxt.prdata = {11'h0, r.st, r.seq_done, r.pins.strobe, r.pins.sel,
                              r.shift, r.core};
            end
        end
        if (acc && apb_req_in.pwrite && apb_req_in.paddr == `SAC_CTRL_OFS) begin
            nxt.restart = apb_req_in.pwdata[`SAC_CTRL_RESTART_BIT];
        end
        // soft power-up: same sequence as a reset, pins already settled
        if (r.restart) begin
            nxt.st = SAC_PUP;
            nxt.cnt = 10'h000;
            nxt.core = `SAC_MAX_WORD;
            // a serial load in the same cycle still counts
            nxt.seq_done = seq_set;
        end
    end

    always_ff @(posedge sys_clk_in) begin
        if (reset_in) begin
            r <= '{st: SAC_PUP, cnt: 10'h000, core: `SAC_MAX_WORD, shift: 8'h00,
                   s1: '0, s2: '0, s3: '0, pins: '0, seq_done: 1'b0,
                   restart: 1'b0, prdata: 32'h0};
        end else begin
            r <= nxt;
        end
    end

    assign prdata_out = r.prdata;
    assign pready_out = 1'b1;
    assign pslverr_out = acc && !mapped;
    assign step_attenuator_word_out = r.core;

    // checks
    sequence s_run_strobe_ser;
        r.st == SAC_RUN && r.pins.strobe && r.pins.sel && !r.restart;
    endsequence

    sequence s_run_strobe_par;
        r.st == SAC_RUN && r.pins.strobe && !r.pins.sel && !r.restart;
    endsequence

    sequence s_enter_dwait;
        r.st == SAC_PUP && r.cnt == `SAC_SETTLE_CYC - 10'h001 && !r.pins.sel
            && r.pins.strobe && !r.restart;
    endsequence

    a_pup_max: assert property (
        @(posedge sys_clk_in) disable iff (reset_in)
        r.st == SAC_PUP |-> r.core == `SAC_MAX_WORD)
        else $error("core not at maximum during power-up");

    a_hold_word: assert property (
        @(posedge sys_clk_in) disable iff (reset_in)
        (r.st == SAC_RUN && !r.pins.strobe && !r.restart) |=> $stable(r.core))
        else $error("core changed without strobe");

    a_direct_entry: assert property (
        @(posedge sys_clk_in) disable iff (reset_in)
        s_enter_dwait |=> r.st == SAC_DWAIT)
        else $error("direct power-up did not start delay");

    a_delay_length: assert property (
        @(posedge sys_clk_in) disable iff (reset_in)
        (s_enter_dwait ##1 1'b1) |-> (r.st == SAC_DWAIT)[*8] and
            (r.st == SAC_DWAIT && r.cnt < PUP_CYC))
        else $error("power-up delay cut short");

    a_delay_max: assert property (
        @(posedge sys_clk_in) disable iff (reset_in)
        r.st == SAC_DWAIT |-> r.core == `SAC_MAX_WORD && r.cnt < PUP_CYC)
        else $error("core not at maximum during delay");

    a_delay_apply: assert property (
        @(posedge sys_clk_in) disable iff (reset_in)
        (r.st == SAC_DWAIT && r.cnt == PUP_CYC - 10'h001 && !r.restart)
            |=> r.st == SAC_RUN && r.core == par_word($past(r.pins.pstep)))
        else $error("preset code not applied after delay");

    a_direct_pass: assert property (
        @(posedge sys_clk_in) disable iff (reset_in)
        s_run_strobe_par |=> r.core == par_word($past(r.pins.pstep)))
        else $error("parallel code not passed to core");

    a_serial_load: assert property (
        @(posedge sys_clk_in) disable iff (reset_in)
        s_run_strobe_ser |=> r.core == $past(r.shift))
        else $error("shift register not copied to core");

    a_shift_lsb: assert property (
        @(posedge sys_clk_in) disable iff (reset_in)
        sclk_rise |=> r.shift == {$past(sdata_new), $past(r.shift[7:1])})
        else $error("shift order wrong");

    a_mode_select: assert property (
        @(posedge sys_clk_in) disable iff (reset_in)
        (s_run_strobe_ser ##0 r.shift[0]) |=> r.core[0])
        else $error("serial select did not use shift register");

endmodule // sac_ctrl

// ==== verif/sac_host_model.sv ====
`timescale 1ns/1ps
module sac_host_model (
    // clock
    input wire logic sys_clk_in,
    // pins to the device
    output sac_pkg::sac_pins_t host_pins_out
);
    import sac_pkg::*;
    initial host_pins_out = '{sel: 1'b1, default: '0};
    task automatic wait_clk(input int n);
        repeat (n) @(posedge sys_clk_in);
    endtask
    task automatic set_pins(input logic s, input logic st, input logic [4:0] p);
        @(posedge sys_clk_in);
        host_pins_out.sel <= s;
        host_pins_out.strobe <= st;
        host_pins_out.pstep <= p;
        wait_clk(6);
    endtask
    task automatic strobe_pulse();
        wait_clk(4);
        host_pins_out.strobe <= 1'b1;
        wait_clk(4);
        host_pins_out.strobe <= 1'b0;
        wait_clk(8);
    endtask
    // sclk 160 ns each phase, still between frames
    task automatic send_word(input logic [7:0] w);
        for (int i = 0; i < 8; i++) begin
            host_pins_out.sdata <= w[i];
            wait_clk(4);
            host_pins_out.sclk <= 1'b1;
            wait_clk(4);
            host_pins_out.sclk <= 1'b0;
        end
        // data no longer held: show the inverse
        host_pins_out.sdata <= ~w[7];
        strobe_pulse();
    endtask
endmodule // sac_host_model

// ==== verif/step_atten_powerup_mode_ctrl_bench.sv ====
`timescale 1ns/1ps
`include "sac_regs.svh"
module step_atten_powerup_mode_ctrl_bench;
    import sac_pkg::*;
    logic sys_clk_in;
    logic reset_in;
    sac_pins_t pins;
    sac_apb_req_t apb;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [7:0] word;
    logic [31:0] rd;
    logic err;
    int num_errors = 0;
    int comparisons = 0;
    initial begin
        sys_clk_in = 1'b0;
        forever #20 sys_clk_in = ~sys_clk_in;
    end
    sac_host_model host (.sys_clk_in(sys_clk_in), .host_pins_out(pins));
    // 400 ns power-up delay keeps the run short: 10 cycles
    sac_ctrl #(.PUP_DELAY_NS(400), .CLK_NS(40)) uut (
        .sys_clk_in(sys_clk_in), .reset_in(reset_in), .host_pins_in(pins),
        .apb_req_in(apb), .prdata_out(prdata), .pready_out(pready),
        .pslverr_out(pslverr), .step_attenuator_word_out(word));
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            num_errors++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic print_verdict();
        $display("errors %0d comparisons %0d", num_errors, comparisons);
        if (num_errors == 0 && comparisons > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    task automatic apb_xfer(input logic wr, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge sys_clk_in);
        apb <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a, pwdata: d};
        @(posedge sys_clk_in);
        apb.penable <= 1'b1;
        do begin
            @(posedge sys_clk_in);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (n >= 50) begin
            num_errors++;
            print_verdict();
        end else begin
            rd = prdata;
            err = pslverr;
            apb <= '0;
        end
    endtask
    task automatic wait_word(input logic [7:0] exp, input int lim);
        int n;
        n = 0;
        while (word !== exp && n < lim) begin
            @(posedge sys_clk_in);
            n++;
        end
        check("word", 32'(word), 32'(exp));
        if (word !== exp) begin
            print_verdict();
        end
    endtask
    task automatic power_up();
        reset_in <= 1'b1;
        repeat (12) @(posedge sys_clk_in);
        reset_in <= 1'b0;
    endtask
    initial begin
        apb <= '0;
        power_up();
        check("word", 32'(word), 32'h3e);
        host.wait_clk(40);
        check("word", 32'(word), 32'h3e);
        apb_xfer(1'b0, `SAC_STATUS_OFS, 32'h0);
        check("status word", 32'(rd[7:0]), 32'h3e);
        check("status flags", 32'(rd[20:16]), 32'h11);
        check("status err", 32'(err), 32'h0);
        // inputs stay low until bit 7 is cleared serially
        host.send_word(8'h32);
        wait_word(8'h32, 20);
        apb_xfer(1'b0, `SAC_STATUS_OFS, 32'h0);
        check("bit7 seen", 32'(rd[18]), 32'h1);
        check("shift", 32'(rd[15:8]), 32'h32);
        host.set_pins(1'b0, 1'b0, 5'h0b);
        host.wait_clk(10);
        check("word", 32'(word), 32'h32);
        host.strobe_pulse();
        wait_word(8'h16, 20);
        host.set_pins(1'b0, 1'b1, 5'h1f);
        wait_word(8'h3e, 20);
        host.set_pins(1'b0, 1'b1, 5'h00);
        wait_word(8'h00, 20);
        host.set_pins(1'b0, 1'b0, 5'h00);
        host.set_pins(1'b1, 1'b0, 5'h00);
        host.send_word(8'h04);
        wait_word(8'h04, 20);
        host.set_pins(1'b0, 1'b1, 5'h05);
        power_up();
        // five settle edges then ten delay edges before the preset applies
        host.wait_clk(14);
        check("word", 32'(word), 32'h3e);
        wait_word(8'h0a, 4);
        host.set_pins(1'b0, 1'b1, 5'h00);
        apb_xfer(1'b1, `SAC_CTRL_OFS, 32'hffff_fffe);
        host.wait_clk(3);
        check("word", 32'(word), 32'h00);
        apb_xfer(1'b1, `SAC_CTRL_OFS, 32'h1);
        host.wait_clk(3);
        check("word", 32'(word), 32'h3e);
        wait_word(8'h00, 40);
        apb_xfer(1'b0, 12'h008, 32'h0);
        check("unmapped err", 32'(err), 32'h1);
        check("unmapped data", rd, 32'h0);
        print_verdict();
    end
endmodule // step_atten_powerup_mode_ctrl_bench
